// ===== pkg/rcdr_pkg.sv
// rcdr_pkg: constants and carrier types for the reset-cause and debug-reset block
// assumes a byte-wide register port driven by the cpu bus or the background debug link
package rcdr_pkg;
	// register positions on the documented register port (addresses of our own)
	localparam logic [1:0] RCS_ADDR = 2'h0;
	localparam logic [1:0] DFR_ADDR = 2'h1;
	// status bit positions
	localparam int POWERON_BIT = 7;
	localparam int PIN_BIT = 6;
	localparam int WATCHDOG_BIT = 5;
	localparam int BAD_OPCODE_BIT = 4;
	localparam int BAD_ADDRESS_BIT = 3;
	localparam int REF_CLK_MISSING_BIT = 2;
	localparam int UNDERVOLTAGE_BIT = 1;
	localparam int FORCE_RESET_BIT = 0;
	// service key values, force-register read value and status reset value
	localparam logic [7:0] SERVICE_KEY1 = 8'h55;
	localparam logic [7:0] SERVICE_KEY2 = 8'haa;
	localparam logic [7:0] DFR_READ_VALUE = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// window watchdog: service allowed in last quarter (3/4 elapsed)
	localparam int WINDOW_NUM = 3;
	localparam int WINDOW_DEN = 4;
	// length of the internal reset request pulse: 20 ns, rounded up to 4 bus clocks
	localparam int RESET_PULSE_NS = 20;
	localparam int CLK_PERIOD_NS = 5;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// reset sources sampled at reset entry
	typedef struct packed {
		logic poweron;
		logic pin;
		logic watchdog;
		logic bad_opcode;
		logic bad_address;
		logic ref_clk_missing;
		logic undervoltage;
		logic forced;
	} rcdr_src_s;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic dbg;
		logic [1:0] addr;
		logic [7:0] wdata;
	} rcdr_req_s;
	// watchdog service sequence
	typedef enum logic [1:0] {
		RCDR_KEY_IDLE = 2'b01,
		RCDR_KEY_GOT1 = 2'b10
	} rcdr_key_e;
endpackage

// ===== src/rcdr_top.sv
// rcdr_top: reset-cause status register, watchdog service decode and debug force reset
// assumes the system reset controller samples the source strobes at reset entry and pulses
// RESET_ENTRY once, and that watchdog counter, voltage monitor and clock monitor live outside
module rcdr_top #(
	parameter int WDOG_CNT_W = 18
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// reset entry and sources sampled at entry
	input wire logic RESET_ENTRY,
	input wire logic SRC_POWERON,
	input wire logic SRC_PIN_N,
	input wire logic SRC_WATCHDOG_TIMEOUT,
	input wire logic SRC_UNDEFINED_OPCODE,
	input wire logic SRC_STOP_EXECUTED,
	input wire logic SRC_HALT_EXECUTED,
	input wire logic SRC_BAD_ADDRESS,
	input wire logic SRC_REF_CLK_MISSING,
	input wire logic SRC_UNDERVOLTAGE,
	// options
	input wire logic WATCHDOG_ENABLE,
	input wire logic WATCHDOG_WINDOW_MODE,
	input wire logic STOP_ALLOWED,
	input wire logic BACKGROUND_MODE_ALLOWED,
	input wire logic UNDERVOLTAGE_RESET_ENABLE,
	// watchdog counter state
	input wire logic [WDOG_CNT_W-1:0] WDOG_COUNT,
	input wire logic [WDOG_CNT_W-1:0] WDOG_PERIOD,
	// register port
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic REG_FROM_DEBUG,
	input wire logic [1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// requests out
	output logic WDOG_CLEAR,
	output logic WDOG_RESET_REQ,
	output logic ILLEGAL_RESET_REQ,
	output logic FORCE_RESET_REQ
);
	logic rst_sync1_ff, rst_sync2_ff;
	logic rst_n;
	logic [7:0] status_ff, nxt_status;
	logic [7:0] rdata_ff, nxt_rdata;
	logic wclr_ff, wrst_ff, ilrst_ff, frc_ff;
	logic frc_pending_ff;
	rcdr_pkg::rcdr_key_e key_ff, nxt_key;
	rcdr_pkg::rcdr_src_s src;
	rcdr_pkg::rcdr_req_s req;

	// reset release through two flops
	// only the release is delayed; a falling RST_N still clears everything at once
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end else begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end
	assign rst_n = rst_sync2_ff;

	// request bundle
	assign req = '{wr: REG_WR, rd: REG_RD, dbg: REG_FROM_DEBUG, addr: REG_ADDR, wdata: REG_WDATA};

	// window start threshold: 3/4 of the period; computed wide to avoid overflow
	// trade-off: two small products instead of a divider, so the threshold is never rounded
	function automatic logic in_closed_window(input logic [WDOG_CNT_W-1:0] cnt,
		input logic [WDOG_CNT_W-1:0] per);
		logic [WDOG_CNT_W+2:0] lhs;
		logic [WDOG_CNT_W+2:0] rhs;
		lhs = {3'h0, cnt} * (WDOG_CNT_W+3)'(rcdr_pkg::WINDOW_DEN);
		rhs = {3'h0, per} * (WDOG_CNT_W+3)'(rcdr_pkg::WINDOW_NUM);
		return lhs < rhs;
	endfunction

	// register write and read decode
	// keys are compared on the whole byte; accesses to unmapped addresses fall away
	wire status_wr = req.wr && req.addr == rcdr_pkg::RCS_ADDR;
	wire dfr_wr = req.wr && req.addr == rcdr_pkg::DFR_ADDR;
	wire status_rd = req.rd && req.addr == rcdr_pkg::RCS_ADDR;
	wire dfr_rd = req.rd && req.addr == rcdr_pkg::DFR_ADDR;
	wire key1 = req.wdata == rcdr_pkg::SERVICE_KEY1;
	wire key2 = req.wdata == rcdr_pkg::SERVICE_KEY2;
	wire window_closed = WATCHDOG_WINDOW_MODE && in_closed_window(WDOG_COUNT, WDOG_PERIOD);
	// bad key or write too early in window mode; only with watchdog enabled
	wire wdog_bad_wr = WATCHDOG_ENABLE && status_wr && (!(key1 || key2) || window_closed);
	wire wdog_service = WATCHDOG_ENABLE && status_wr && key2 && !window_closed
		&& key_ff == rcdr_pkg::RCDR_KEY_GOT1;
	// only the debug link may force a reset; cpu writes fall away
	wire force_wr = dfr_wr && req.dbg && req.wdata[rcdr_pkg::FORCE_RESET_BIT];
	// illegal instruction classes folded into one cause
	wire bad_op = SRC_UNDEFINED_OPCODE || (SRC_STOP_EXECUTED && !STOP_ALLOWED)
		|| (SRC_HALT_EXECUTED && !BACKGROUND_MODE_ALLOWED);
	wire uv_reset = SRC_UNDERVOLTAGE && UNDERVOLTAGE_RESET_ENABLE;
	// causes that restart the system at once; undervoltage only when its reset is enabled
	wire other_reset = bad_op || SRC_BAD_ADDRESS || SRC_REF_CLK_MISSING || uv_reset;

	// sources active at reset entry
	// the forced cause comes from a marker, since the debug write lands before the entry
	assign src = '{
		poweron: SRC_POWERON,
		pin: !SRC_PIN_N,
		watchdog: SRC_WATCHDOG_TIMEOUT && WATCHDOG_ENABLE,
		bad_opcode: bad_op,
		bad_address: SRC_BAD_ADDRESS,
		ref_clk_missing: SRC_REF_CLK_MISSING,
		undervoltage: uv_reset || SRC_POWERON,
		forced: frc_pending_ff
	};

	// status capture: flags change only at reset entry, never by a write
	// a forced entry clears every flag even with live sources beside it
	// bit 0 has no source and stays low whatever the entry brings
	always_comb begin
		nxt_status = status_ff;
		if (RESET_ENTRY) begin
			nxt_status = 8'h00;
			if (!src.forced) begin
				nxt_status[rcdr_pkg::POWERON_BIT] = src.poweron ||
					(!src.poweron && src.undervoltage && status_ff[rcdr_pkg::POWERON_BIT]);
				nxt_status[rcdr_pkg::PIN_BIT] = src.pin;
				nxt_status[rcdr_pkg::WATCHDOG_BIT] = src.watchdog;
				nxt_status[rcdr_pkg::BAD_OPCODE_BIT] = src.bad_opcode;
				nxt_status[rcdr_pkg::BAD_ADDRESS_BIT] = src.bad_address;
				nxt_status[rcdr_pkg::REF_CLK_MISSING_BIT] = src.ref_clk_missing;
				nxt_status[rcdr_pkg::UNDERVOLTAGE_BIT] = src.undervoltage;
			end
			nxt_status[0] = 1'b0;
		end
	end

	// service sequence tracker; any other status write restarts it
	// it runs with the watchdog off too, so enabling it between the keys still completes
	always_comb begin
		nxt_key = key_ff;
		case (key_ff)
			rcdr_pkg::RCDR_KEY_IDLE: if (status_wr && key1) nxt_key = rcdr_pkg::RCDR_KEY_GOT1;
			rcdr_pkg::RCDR_KEY_GOT1: if (status_wr && !key1) nxt_key = rcdr_pkg::RCDR_KEY_IDLE;
			default: nxt_key = rcdr_pkg::RCDR_KEY_IDLE;
		endcase
	end

	// read data: force-reset register always reads zero, unmapped reads zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (status_rd)
			nxt_rdata = status_ff;
		else if (dfr_rd)
			nxt_rdata = rcdr_pkg::DFR_READ_VALUE;
	end

	// status register: it clears only when the whole block is reset; a system reset
	// is announced by RESET_ENTRY instead, so the cause stays readable afterwards
	// limitation: the port reset must therefore never be wired to the system reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			status_ff <= rcdr_pkg::STATUS_RESET;
		else
			status_ff <= nxt_status;
	end

	// forced-reset marker held until reset entry consumes it
	// a force write in the same cycle as an entry is kept for the next entry
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			frc_pending_ff <= 1'b0;
		else if (force_wr)
			frc_pending_ff <= 1'b1; // set wins over consume
		else if (RESET_ENTRY)
			frc_pending_ff <= 1'b0;
	end

	// registered outputs
	// every request leaves a flop, so the reset controller never sees a decode glitch
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			key_ff <= rcdr_pkg::RCDR_KEY_IDLE;
			rdata_ff <= 8'h00;
			wclr_ff <= 1'b0;
			wrst_ff <= 1'b0;
			ilrst_ff <= 1'b0;
			frc_ff <= 1'b0;
		end else begin
			key_ff <= nxt_key;
			rdata_ff <= nxt_rdata;
			wclr_ff <= wdog_service;
			wrst_ff <= wdog_bad_wr;
			ilrst_ff <= other_reset;
			frc_ff <= force_wr;
		end
	end

	// ports are straight flop outputs
	assign REG_RDATA = rdata_ff;
	assign WDOG_CLEAR = wclr_ff;
	assign WDOG_RESET_REQ = wrst_ff;
	assign ILLEGAL_RESET_REQ = ilrst_ff;
	assign FORCE_RESET_REQ = frc_ff;
endmodule // rcdr_top

// ===== verif/rcdr_properties.sv
// rcdr_properties: port-level checks of the reset-cause block
// assumes it is bound into rcdr_top
module rcdr_properties #(
	parameter int WDOG_CNT_W = 18
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// watchdog options and state
	input wire logic WATCHDOG_ENABLE,
	input wire logic WATCHDOG_WINDOW_MODE,
	input wire logic [WDOG_CNT_W-1:0] WDOG_COUNT,
	input wire logic [WDOG_CNT_W-1:0] WDOG_PERIOD,
	// register port and requests
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic REG_FROM_DEBUG,
	input wire logic [1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic WDOG_CLEAR,
	input wire logic WDOG_RESET_REQ,
	input wire logic FORCE_RESET_REQ
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// status and force-register writes and key values, shared by the watchdog and force checks
	wire st_wr = REG_WR && REG_ADDR == 2'h0;
	wire key = REG_WDATA == 8'h55 || REG_WDATA == 8'haa;
	wire f_wr = REG_WR && REG_ADDR == 2'h1;
	f_read_a: assert property (REG_RD && REG_ADDR == 2'h1 |=> REG_RDATA == 8'h00) else $error("rdata");
	bit0_zero_a: assert property (REG_RD |=> !REG_RDATA[0]) else $error("bit 0");
	cpu_force_a: assert property (f_wr && !REG_FROM_DEBUG |=> !FORCE_RESET_REQ) else $error("cpu force");
	dbg_force_a: assert property (f_wr && REG_FROM_DEBUG |=> FORCE_RESET_REQ == $past(REG_WDATA[0]))
		else $error("dbg force");
	bad_key_a: assert property (WATCHDOG_ENABLE && st_wr && !key |=> WDOG_RESET_REQ) else $error("bad key");
	wdog_off_a: assert property (!WATCHDOG_ENABLE |=> !WDOG_RESET_REQ) else $error("wdog off");
	// keys one idle edge apart, as the host model spaces them; a status write other than 8'h55 between breaks the pair
	svc_clear_a: assert property (st_wr && REG_WDATA == 8'h55 ##1 !st_wr ##1 st_wr && REG_WDATA == 8'haa
		&& WATCHDOG_ENABLE && !WATCHDOG_WINDOW_MODE |=> WDOG_CLEAR) else $error("no clear");
	win_shut_a: assert property (WATCHDOG_ENABLE && WATCHDOG_WINDOW_MODE && st_wr
		&& 32'h4 * WDOG_COUNT < 32'h3 * WDOG_PERIOD |=> WDOG_RESET_REQ) else $error("window");
endmodule // rcdr_properties
bind rcdr_top rcdr_properties #(.WDOG_CNT_W(WDOG_CNT_W)) props (.CLK, .RST_N, .WATCHDOG_ENABLE,
	.WATCHDOG_WINDOW_MODE, .WDOG_COUNT, .WDOG_PERIOD, .REG_WR, .REG_RD, .REG_FROM_DEBUG, .REG_ADDR,
	.REG_WDATA, .REG_RDATA, .WDOG_CLEAR, .WDOG_RESET_REQ, .FORCE_RESET_REQ);

// ===== verif/rcdr_host.sv
// rcdr_host: cpu and debug-link master for the register port
// assumes requests are taken on the rising CLK edge where a strobe is high
module rcdr_host (
	// clock
	input wire logic CLK,
	// request out, read data in
	output rcdr_pkg::rcdr_req_s q,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial q = '{wr: 1'b0, rd: 1'b0, dbg: 1'b0, addr: 2'h3, wdata: 8'h5a};
	// idle lines invert so a stale value never passes for a fresh one
	task xfer(input logic w, d, input logic [1:0] a, input logic [7:0] v, output logic [7:0] r);
		@(posedge CLK) #1;
		q = '{wr: w, rd: !w, dbg: d, addr: a, wdata: v};
		@(posedge CLK) #1;
		r = rdata;
		q = '{wr: 1'b0, rd: 1'b0, dbg: 1'b0, addr: ~a, wdata: ~v};
	endtask
endmodule // rcdr_host

// ===== verif/tb.sv
// tb: self-checking bench for the reset-cause block
// assumes a 200 MHz bus clock and rcdr_host as the only register master
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic ent = 1'b0;
	logic en = 1'b1;
	logic win = 1'b0;
	logic [8:0] src = 9'h000;
	logic [17:0] cnt = 18'h00000;
	logic [17:0] per = 18'h00190;
	logic [7:0] rd;
	logic [7:0] r;
	logic wclr, wrst, frst, ilr;
	logic stp = 1'b0;
	logic bgm = 1'b0;
	logic uve = 1'b1;
	int errors = 0;
	int checks = 0;
	rcdr_pkg::rcdr_req_s q;
	logic [8:0] sv [9] = '{9'h100, 9'h001, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002};
	logic [7:0] ev [9] = '{8'h82, 8'h82, 8'h40, 8'h20, 8'h10, 8'h10, 8'h10, 8'h08, 8'h04};
	always #2.5 CLK = ~CLK;
	rcdr_host host (.CLK(CLK), .q(q), .rdata(rd));
	// stop and halt count as bad opcodes while their allow inputs are low
	rcdr_top uut (.CLK(CLK), .RST_N(RST_N), .RESET_ENTRY(ent), .SRC_POWERON(src[8]), .SRC_PIN_N(!src[7]),
		.SRC_WATCHDOG_TIMEOUT(src[6]), .SRC_UNDEFINED_OPCODE(src[5]), .SRC_STOP_EXECUTED(src[4]),
		.SRC_HALT_EXECUTED(src[3]), .SRC_BAD_ADDRESS(src[2]), .SRC_REF_CLK_MISSING(src[1]),
		.SRC_UNDERVOLTAGE(src[0]), .WATCHDOG_ENABLE(en), .WATCHDOG_WINDOW_MODE(win), .STOP_ALLOWED(stp),
		.BACKGROUND_MODE_ALLOWED(bgm), .UNDERVOLTAGE_RESET_ENABLE(uve), .WDOG_COUNT(cnt), .WDOG_PERIOD(per),
		.REG_WR(q.wr), .REG_RD(q.rd), .REG_FROM_DEBUG(q.dbg), .REG_ADDR(q.addr), .REG_WDATA(q.wdata),
		.REG_RDATA(rd), .WDOG_CLEAR(wclr), .WDOG_RESET_REQ(wrst), .ILLEGAL_RESET_REQ(ilr), .FORCE_RESET_REQ(frst));
	task chk(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// one reset entry with the given sources, then a status read
	task boot(input logic [8:0] s, input logic [7:0] e, input logic il);
		@(posedge CLK) #1;
		src = s;
		ent = 1'b1;
		@(posedge CLK) #1;
		chk("illegal", {7'h00, ilr}, {7'h00, il});
		ent = 1'b0;
		src = 9'h000;
		host.xfer(1'b0, 1'b0, 2'h0, 8'h00, r);
		chk("status", r, e);
	endtask
	// write, then compare {clear, watchdog reset, force reset}
	task put(input logic d, input logic [1:0] a, input logic [7:0] v, input logic [2:0] e);
		host.xfer(1'b1, d, a, v, r);
		chk("requests", {5'h00, wclr, wrst, frst}, {5'h00, e});
	endtask
	task conclude;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge CLK);
		#1 RST_N = 1'b1;
		repeat (3) @(posedge CLK);
		for (int i = 0; i < 9; i++) boot(sv[i], ev[i], |sv[i][5:0]);
		put(1'b0, 2'h0, 8'h55, 3'h0);
		put(1'b0, 2'h0, 8'haa, 3'h4);
		put(1'b0, 2'h0, 8'h12, 3'h2);
		host.xfer(1'b0, 1'b0, 2'h0, 8'h00, r);
		chk("status kept", r, 8'h04);
		put(1'b0, 2'h1, 8'h01, 3'h0);
		put(1'b1, 2'h1, 8'h00, 3'h0);
		host.xfer(1'b0, 1'b1, 2'h1, 8'h00, r);
		chk("force read", r, 8'h00);
		win = 1'b1;
		cnt = 18'h00064;
		put(1'b0, 2'h0, 8'h55, 3'h2);
		cnt = 18'h0015e;
		put(1'b0, 2'h0, 8'h55, 3'h0);
		put(1'b0, 2'h0, 8'haa, 3'h4);
		en = 1'b0;
		put(1'b0, 2'h0, 8'h12, 3'h0);
		boot(9'h040, 8'h00, 1'b0);
		put(1'b1, 2'h1, 8'h01, 3'h1);
		boot(9'h080, 8'h00, 1'b0);
		stp = 1'b1;
		bgm = 1'b1;
		uve = 1'b0;
		boot(9'h019, 8'h00, 1'b0);
		conclude;
	end
endmodule // tb
